// File: design/flash_self_prog_pkg.sv
// package: register map, field layout and timing for the self-programming controller
package flash_self_prog_pkg;
	// ==========================================================
	// register byte offsets
	localparam logic [3:0] ctrl_offset = 4'h0;
	localparam logic [3:0] pointer_offset = 4'h4;
	localparam logic [3:0] data_offset = 4'h8;
	localparam logic [3:0] lock_offset = 4'hc;
	// ==========================================================
	// store control register fields
	localparam int store_enable_pos = 0;
	localparam int page_erase_pos = 1;
	localparam int page_write_pos = 2;
	localparam int lock_set_pos = 3;
	localparam int read_reenable_pos = 4;
	localparam int busy_pos = 6;
	localparam logic [4:0] cmd_erase = 5'h03;
	localparam logic [4:0] cmd_load = 5'h01;
	localparam logic [4:0] cmd_write = 5'h05;
	localparam logic [4:0] cmd_reenable = 5'h11;
	localparam logic [4:0] cmd_lock_set = 5'h09;
	localparam logic [7:0] ctrl_reset = 8'h00;
	// ==========================================================
	// lock register: boot lock bits, 1 = unprogrammed
	localparam int app_write_protect_pos = 2;
	localparam int app_read_protect_pos = 3;
	localparam int boot_write_protect_pos = 4;
	localparam int boot_read_protect_pos = 5;
	localparam logic [3:0] lock_reset = 4'hf;
	// ==========================================================
	// geometry and timing
	localparam int page_words = 64;
	localparam int page_count = 128;
	localparam int arm_window_cycles = 4;
	localparam int clock_mhz = 20;
	localparam int prog_time_us = 4000;
	localparam int prog_cycles = prog_time_us * clock_mhz;
	localparam logic [13:0] boot_start_default = 14'h3f00;
	typedef enum logic [3:0] {
		st_idle = 4'b0001,
		st_armed = 4'b0010,
		st_busy = 4'b0100,
		st_done = 4'b1000
	} seq_state_type;
	typedef struct packed {
		logic valid;
		logic from_boot;
		logic [15:0] addr;
	} core_access_type;
endpackage : flash_self_prog_pkg

// File: design/page_store_array.sv
// flash array with a one-page temporary buffer
module page_store_array #(
	parameter int words = 8192,
	parameter int page_words = 64
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic buf_we,
	input wire logic [5:0] buf_word,
	input wire logic [15:0] buf_data,
	input wire logic page_erase,
	input wire logic page_write,
	input wire logic [6:0] page,
	input wire logic rd_en,
	input wire logic [12:0] rd_word,
	output logic [15:0] rd_data
);
	logic [15:0] mem [words];
	logic [15:0] page_buf [page_words];
	// ==========================================================
	// buffer fill, any word order; cleared after each page write
	always_ff @(posedge aclk) begin
		for (int i = 0; i < page_words; i++) begin
			if (!aresetn || page_write) begin
				page_buf[i] <= 16'hffff;
			end else if (buf_we && buf_word == 6'(i)) begin // see (RL6)
				page_buf[i] <= buf_data;
			end
		end
	end
	// ==========================================================
	// whole-page erase or write only, never single words
	always_ff @(posedge aclk) begin
		for (int i = 0; i < page_words; i++) begin
			if (page_erase) begin
				mem[{page, 6'(i)}] <= 16'hffff; // see (RL1)
			end else if (page_write) begin
				mem[{page, 6'(i)}] <= mem[{page, 6'(i)}] & page_buf[i]; // see (RL1)
			end
		end
	end
	// read is combinational so the caller's output flop sees the word of this very load
	assign rd_data = rd_en ? mem[rd_word] : 16'h0000;
endmodule : page_store_array

// File: design/boot_self_program_flash_ctrl.sv
// self-programming flash controller with axi4-lite register access
// How it works
// (RL1) program whole 64-word pages through buffer
// (RL2) code 00011 plus store within four: erase
// (RL3) erase page from pointer bits 13..7
// (RL4) code 00001 plus store: buffer load
// (RL5) buffer word from pointer bits 6..1
// (RL6) buffer words load in any order
// (RL7) code 00101 plus store: page write
// (RL8) firmware zeroes pointer bits 6..0 writing
// (RL9) firmware erases same page before write
// (RL10) general lock bits ignored here
// (RL11) core halted; store enable clears when done
// (RL12) firmware pads ffff and nop after
// (RL13) firmware issues 10001 then checks busy
// (RL14) busy and reenable have no effect
// (RL15) firmware avoids application reads while busy
// (RL16) boot code reaches whole flash
// (RL17) lock bits only clear by chip erase
// (RL18) application lock pair blocks writes, reads
// (RL19) boot lock pair blocks writes, reads
// (RL20) boot read lock masks boot interrupts
// (RL21) lock bits read 1 unprogrammed, 0 programmed
// (RL22) armed bits clear on done or timeout
// (RL23) stores only from boot section count
// (RL24) forbidden store changes nothing, disarms
module boot_self_program_flash_ctrl #(
	parameter int prog_cycles = flash_self_prog_pkg::prog_cycles,
	parameter logic [13:0] boot_start = flash_self_prog_pkg::boot_start_default
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire flash_self_prog_pkg::core_access_type store_instr,
	input wire flash_self_prog_pkg::core_access_type program_load_instr,
	input wire logic chip_erase,
	output logic core_halt,
	output logic interrupt_block,
	output logic load_blocked,
	output logic [15:0] load_data
);
	localparam int cnt_w = $clog2(prog_cycles + 1);
	flash_self_prog_pkg::seq_state_type state_r;
	logic [4:0] cmd_r;
	logic [15:0] pointer_r;
	logic [15:0] data_register_pair;
	logic [3:0] lock_r;
	logic [2:0] arm_cnt_r;
	logic [cnt_w-1:0] busy_cnt_r;
	logic do_erase_r;
	logic do_write_r;
	logic buf_we;
	logic aw_held_r;
	logic w_held_r;
	logic [3:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic [15:0] array_rd;
	// ==========================================================
	// address decode helpers
	function automatic logic in_boot(input logic [15:0] a);
		in_boot = a[14:1] >= {1'b0, boot_start[13:1]} ? a[13:1] >= boot_start[13:1] : 1'b0;
	endfunction : in_boot
	function automatic logic write_allowed(input logic [3:0] lk, input logic [6:0] page);
		// general lock bits deliberately not consulted
		if (in_boot({2'b00, page, 7'h00})) begin
			write_allowed = lk[flash_self_prog_pkg::boot_write_protect_pos - 2]; // see (RL19) (RL10)
		end else begin
			write_allowed = lk[flash_self_prog_pkg::app_write_protect_pos - 2]; // see (RL18) (RL10)
		end
	endfunction : write_allowed
	// ==========================================================
	// axi write channel: address and data in either order
	wire wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			aw_addr_r <= 4'h0;
			s_axi_awready <= 1'b0;
		end else begin
			// ready must not wait for valid to drop, or a waiting master would hang
			s_axi_awready <= !aw_held_r;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end else if (wr_go) begin
				aw_held_r <= 1'b0;
			end
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_r <= 1'b0;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_wready <= !w_held_r;
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end else if (wr_go) begin
				w_held_r <= 1'b0;
			end
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (aw_addr_r[1:0] == 2'b00) ? 2'b00 : 2'b10;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end
	wire ctrl_wr = wr_go && aw_addr_r == flash_self_prog_pkg::ctrl_offset && w_strb_r[0] && state_r != flash_self_prog_pkg::st_busy;
	// ==========================================================
	// pointer and data pair registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pointer_r <= 16'h0000;
			data_register_pair <= 16'h0000;
		end else if (wr_go) begin
			if (aw_addr_r == flash_self_prog_pkg::pointer_offset) begin
				if (w_strb_r[0]) pointer_r[7:0] <= w_data_r[7:0];
				if (w_strb_r[1]) pointer_r[15:8] <= w_data_r[15:8];
			end
			if (aw_addr_r == flash_self_prog_pkg::data_offset) begin
				if (w_strb_r[0]) data_register_pair[7:0] <= w_data_r[7:0];
				if (w_strb_r[1]) data_register_pair[15:8] <= w_data_r[15:8];
			end
		end
	end
	// ==========================================================
	// command sequencer
	wire store_hit = store_instr.valid && store_instr.from_boot; // see (RL23)
	wire [6:0] page_sel = pointer_r[13:7]; // see (RL3)
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= flash_self_prog_pkg::st_idle;
			cmd_r <= 5'h00;
			arm_cnt_r <= 3'h0;
			busy_cnt_r <= '0;
			do_erase_r <= 1'b0;
			do_write_r <= 1'b0;
			buf_we <= 1'b0;
		end else begin
			do_erase_r <= 1'b0;
			do_write_r <= 1'b0;
			buf_we <= 1'b0;
			case (state_r)
				flash_self_prog_pkg::st_idle: begin
					if (ctrl_wr && w_data_r[flash_self_prog_pkg::store_enable_pos]) begin
						cmd_r <= w_data_r[4:0];
						arm_cnt_r <= 3'(flash_self_prog_pkg::arm_window_cycles);
						state_r <= flash_self_prog_pkg::st_armed;
					end
				end
				flash_self_prog_pkg::st_armed: begin
					if (store_hit) begin
						state_r <= flash_self_prog_pkg::st_done;
						case (cmd_r)
							flash_self_prog_pkg::cmd_erase: begin
								if (write_allowed(lock_r, page_sel)) begin // see (RL24)
									do_erase_r <= 1'b1; // see (RL2) (RL16)
								end
								busy_cnt_r <= cnt_w'(prog_cycles);
								state_r <= flash_self_prog_pkg::st_busy; // see (RL11)
							end
							flash_self_prog_pkg::cmd_write: begin
								busy_cnt_r <= cnt_w'(prog_cycles);
								state_r <= flash_self_prog_pkg::st_busy; // see (RL7) (RL11)
							end
							flash_self_prog_pkg::cmd_load: begin
								buf_we <= 1'b1; // see (RL4)
							end
							flash_self_prog_pkg::cmd_lock_set: begin
								busy_cnt_r <= cnt_w'(prog_cycles);
								state_r <= flash_self_prog_pkg::st_busy;
							end
							default: begin
								// re-enable has no effect here; see (RL14)
							end
						endcase
					end else if (arm_cnt_r == 3'h1) begin
						state_r <= flash_self_prog_pkg::st_idle; // see (RL22)
						cmd_r <= 5'h00;
					end else begin
						arm_cnt_r <= arm_cnt_r - 3'h1;
					end
				end
				flash_self_prog_pkg::st_busy: begin
					if (busy_cnt_r == cnt_w'(1)) begin
						// commit at end so the page is stable while halted
						do_write_r <= cmd_r == flash_self_prog_pkg::cmd_write && write_allowed(lock_r, page_sel); // see (RL24)
						state_r <= flash_self_prog_pkg::st_done;
					end else begin
						busy_cnt_r <= busy_cnt_r - cnt_w'(1);
					end
				end
				flash_self_prog_pkg::st_done: begin
					state_r <= flash_self_prog_pkg::st_idle; // see (RL22) (RL11)
					cmd_r <= 5'h00;
				end
				default: begin
					state_r <= flash_self_prog_pkg::st_idle;
				end
			endcase
		end
	end
	// ==========================================================
	// boot lock bits: only programmed (1->0) by software; chip erase restores
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lock_r <= flash_self_prog_pkg::lock_reset;
		end else if (chip_erase) begin
			lock_r <= flash_self_prog_pkg::lock_reset; // see (RL17)
		end else if (state_r == flash_self_prog_pkg::st_busy && busy_cnt_r == cnt_w'(1)
				&& cmd_r == flash_self_prog_pkg::cmd_lock_set) begin
			lock_r <= lock_r & data_register_pair[5:2]; // see (RL17) (RL21)
		end
	end
	// ==========================================================
	// core-facing outputs
	wire load_in_boot = in_boot(program_load_instr.addr);
	wire load_deny = program_load_instr.from_boot ? (!load_in_boot && !lock_r[1]) // see (RL18)
		: (load_in_boot && !lock_r[3]); // see (RL19)
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			core_halt <= 1'b0;
			interrupt_block <= 1'b0;
			load_blocked <= 1'b0;
			load_data <= 16'h0000;
		end else begin
			core_halt <= state_r == flash_self_prog_pkg::st_busy; // see (RL11)
			interrupt_block <= store_instr.from_boot && !lock_r[3]; // see (RL20)
			load_blocked <= program_load_instr.valid && load_deny;
			load_data <= (program_load_instr.valid && !load_deny) ? array_rd : 16'h0000;
		end
	end
	page_store_array #(
		.words(flash_self_prog_pkg::page_count * flash_self_prog_pkg::page_words),
		.page_words(flash_self_prog_pkg::page_words)
	) u_array (
		.aclk(aclk),
		.aresetn(aresetn),
		.buf_we(buf_we),
		.buf_word(pointer_r[6:1]), // see (RL5)
		.buf_data(data_register_pair),
		.page_erase(do_erase_r),
		.page_write(do_write_r),
		.page(page_sel),
		.rd_en(program_load_instr.valid),
		.rd_word(program_load_instr.addr[13:1]),
		.rd_data(array_rd)
	);
	// ==========================================================
	// axi read channel; busy flag and upper bits always zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'b00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'b00;
			case (s_axi_araddr)
				flash_self_prog_pkg::ctrl_offset: s_axi_rdata <= {27'h0, cmd_r}; // see (RL14) (RL11)
				flash_self_prog_pkg::pointer_offset: s_axi_rdata <= {16'h0000, pointer_r};
				flash_self_prog_pkg::data_offset: s_axi_rdata <= {16'h0000, data_register_pair};
				flash_self_prog_pkg::lock_offset: s_axi_rdata <= {26'h0, lock_r, 2'b11}; // see (RL21)
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= 2'b10;
				end
			endcase
		end else if (s_axi_rvalid) begin
			if (s_axi_rready) s_axi_rvalid <= 1'b0;
		end else begin
			s_axi_arready <= 1'b1;
		end
	end
endmodule : boot_self_program_flash_ctrl

// File: bench/flash_ctrl_sva.sv
// checker: timing relations at the self-programming controller ports
module flash_ctrl_sva #(
	parameter int prog_cycles = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire flash_self_prog_pkg::core_access_type store_instr,
	input wire flash_self_prog_pkg::core_access_type program_load_instr,
	input wire logic core_halt,
	input wire logic interrupt_block,
	input wire logic load_blocked,
	input wire logic [15:0] load_data
);
	// ==========
	// helpers
	int halt_cnt_r;
	logic [2:0] boot_store_r;
	logic load_seen_r;
	always_ff @(posedge aclk) begin
		if (!aresetn) halt_cnt_r <= 0;
		else if (core_halt) halt_cnt_r <= halt_cnt_r + 1;
		else halt_cnt_r <= 0;
	end
	// halt may start a cycle or two after the store, so keep three cycles of history
	always_ff @(posedge aclk) begin
		if (!aresetn) boot_store_r <= 3'h0;
		else boot_store_r <= {boot_store_r[1:0], store_instr.valid & store_instr.from_boot};
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) load_seen_r <= 1'b0;
		else load_seen_r <= program_load_instr.valid;
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence halt_start; $rose(core_halt); endsequence
	sequence halt_end; $fell(core_halt); endsequence
	sequence ar_taken; s_axi_arvalid && s_axi_arready; endsequence
	// ==========
	// assertions
	chk_halt_cause: assert property (halt_start |-> boot_store_r != 3'h0)
		else $error("halt without a recent boot store");
	chk_halt_length: assert property (halt_end |-> halt_cnt_r == prog_cycles)
		else $error("halt length differs from programming time");
	chk_int_block: assert property ($rose(interrupt_block) |-> boot_store_r[0])
		else $error("interrupt block without a boot store");
	chk_denied_zero: assert property (load_blocked |-> load_data == 16'h0)
		else $error("denied load returned data");
	chk_denied_cause: assert property (load_blocked |-> load_seen_r)
		else $error("load blocked without a load");
	chk_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("read data dropped early");
	chk_read_answer: assert property (ar_taken |=> s_axi_rvalid)
		else $error("read answer late");
endmodule : flash_ctrl_sva

bind boot_self_program_flash_ctrl flash_ctrl_sva #(.prog_cycles(prog_cycles)) flash_ctrl_sva_inst (.aclk(aclk),
	.aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.store_instr(store_instr), .program_load_instr(program_load_instr), .core_halt(core_halt),
	.interrupt_block(interrupt_block), .load_blocked(load_blocked), .load_data(load_data));

// File: bench/core_model.sv
// core model: boot loader firmware issuing store and load instructions
module core_model (
	input wire logic aclk,
	output flash_self_prog_pkg::core_access_type store_instr,
	output flash_self_prog_pkg::core_access_type program_load_instr
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		store_instr = '0;
		program_load_instr = '0;
	end
	// ==========
	// store: one-cycle store; op calls it right after the arming write answers, so it lands inside the window;
	// firmware erases before writing the same page, zeroes low pointer bits for a write,
	// pads after programming stores and reads no application code while halted
	task automatic store(input logic boot);
		store_instr <= '{1'b1, boot, 16'h3f80};
		@(posedge aclk);
		store_instr <= '{1'b0, ~boot, 16'hc07f};
	endtask : store
	// ==========
	// load: one-cycle load, address inverted once released
	task automatic load(input logic boot, input logic [15:0] a);
		@(posedge aclk);
		program_load_instr <= '{1'b1, boot, a};
		@(posedge aclk);
		program_load_instr <= '{1'b0, ~boot, ~a};
	endtask : load
endmodule : core_model

// File: bench/test_boot_self_program_flash_ctrl.sv
// testbench: self-programming controller over axi4-lite and a core model
module test_boot_self_program_flash_ctrl;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [3:0] ctl = flash_self_prog_pkg::ctrl_offset;
	localparam logic [3:0] ptr = flash_self_prog_pkg::pointer_offset;
	localparam logic [3:0] dat = flash_self_prog_pkg::data_offset;
	localparam logic [3:0] lck = flash_self_prog_pkg::lock_offset;
	localparam logic [6:0] pg = 7'h05;
	logic aclk, aresetn, chip_erase, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic core_halt, interrupt_block, load_blocked;
	logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [15:0] load_data;
	flash_self_prog_pkg::core_access_type store_instr, program_load_instr;
	int bad_count, n_compared;
	boot_self_program_flash_ctrl #(.prog_cycles(8)) boot_self_program_flash_ctrl_inst (.aclk, .aresetn,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .store_instr, .program_load_instr, .chip_erase, .core_halt,
		.interrupt_block, .load_blocked, .load_data);
	core_model core_model_inst (.aclk, .store_instr, .program_load_instr);
	// ==========
	// tasks
	task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", what, e, g);
		end
	endtask : check
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		rsp = s_axi_bresp;
	endtask : wr
	task automatic rd(input logic [3:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		rd_v = s_axi_rdata;
		rsp = s_axi_rresp;
	endtask : rd
	// arm, store at once, then poll until the enable bit drops
	task automatic op(input logic [4:0] c);
		wr(ctl, {27'h0, c});
		core_model_inst.store(1'b1);
		do rd(ctl); while (rd_v[0] !== 1'b0);
		check("ctrl idle", 32'h0, rd_v & 32'h5f);
	endtask : op
	task automatic ld(input logic boot, input logic [15:0] a, input logic [15:0] e, input logic b);
		core_model_inst.load(boot, a);
		#1;
		check("load data", {16'h0, e}, {16'h0, load_data});
		check("load blocked", {31'h0, b}, {31'h0, load_blocked});
	endtask : ld
	task automatic test_done;
		$display("comparisons %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : test_done
	// ==========
	// clock, watchdog, tests
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	initial begin
		repeat (20000) @(posedge aclk);
		bad_count++;
		test_done();
	end
	initial begin
		{aresetn, chip_erase, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h0;
		s_axi_awaddr = 4'h0;
		s_axi_araddr = 4'h0;
		s_axi_wstrb = 4'hf;
		s_axi_wdata = 32'h0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		rd(lck);
		check("lock reset", 32'h3f, rd_v & 32'h3f);
		rd(4'h6);
		check("unaligned read", 32'h2, {30'h0, rsp});
		wr(4'h2, 32'h0);
		check("unaligned write", 32'h2, {30'h0, rsp});
		wr(ptr, {18'h3, pg, 7'h7f});
		check("write resp", 32'h0, {30'h0, rsp});
		op(flash_self_prog_pkg::cmd_erase);
		wr(ptr, {18'h0, pg, 7'h7e});
		wr(dat, 32'h1234);
		op(flash_self_prog_pkg::cmd_load);
		wr(ptr, {18'h0, pg, 7'h00});
		wr(dat, 32'h5a0f);
		op(flash_self_prog_pkg::cmd_load);
		op(flash_self_prog_pkg::cmd_write);
		ld(1'b1, {2'h0, pg, 7'h7e}, 16'h1234, 1'b0);
		ld(1'b1, {2'h0, pg, 7'h00}, 16'h5a0f, 1'b0);
		ld(1'b1, {2'h0, pg, 7'h02}, 16'hffff, 1'b0);
		// late store and application store must both leave the page alone
		wr(ctl, {27'h0, flash_self_prog_pkg::cmd_erase});
		repeat (6) @(posedge aclk);
		core_model_inst.store(1'b1);
		wr(ctl, {27'h0, flash_self_prog_pkg::cmd_erase});
		core_model_inst.store(1'b0);
		repeat (6) @(posedge aclk);
		rd(ctl);
		check("ctrl expired", 32'h0, rd_v & 32'h1f);
		ld(1'b1, {2'h0, pg, 7'h7e}, 16'h1234, 1'b0);
		wr(dat, 32'hfb);
		op(flash_self_prog_pkg::cmd_lock_set);
		rd(lck);
		check("lock app write", 32'h3b, rd_v & 32'h3f);
		op(flash_self_prog_pkg::cmd_erase);
		ld(1'b1, {2'h0, pg, 7'h7e}, 16'h1234, 1'b0);
		wr(dat, 32'hff);
		op(flash_self_prog_pkg::cmd_lock_set);
		rd(lck);
		check("lock kept", 32'h3b, rd_v & 32'h3f);
		@(posedge aclk);
		chip_erase <= 1'b1;
		@(posedge aclk);
		chip_erase <= 1'b0;
		rd(lck);
		check("lock cleared", 32'h3f, rd_v & 32'h3f);
		wr(dat, 32'hd7);
		op(flash_self_prog_pkg::cmd_lock_set);
		ld(1'b1, {2'h0, pg, 7'h7e}, 16'h0, 1'b1);
		ld(1'b0, 16'h3fc0, 16'h0, 1'b1);
		ld(1'b0, {2'h0, pg, 7'h7e}, 16'h1234, 1'b0);
		core_model_inst.store(1'b1);
		#1;
		check("interrupt block", 32'h1, {31'h0, interrupt_block});
		op(flash_self_prog_pkg::cmd_reenable);
		test_done();
	end
endmodule : test_boot_self_program_flash_ctrl
